// File: inc/lcb_pkg.sv
// Constants, types and encodings for the logic/compare/branch slice.
// Assumes one core clock and a synchronous active-low reset.
// ---------------------------------------------------------------
// Notes on behaviour
// - AND accumulator with working register r; one byte, one cycle.
// - AND accumulator with direct byte from byte two; two bytes, one cycle.
// - AND accumulator with RAM at pointer register; one byte, one cycle.
// - AND accumulator with immediate byte two; two bytes, one cycle.
// - AND direct byte with accumulator, write back there; two bytes, one cycle.
// - AND direct byte with immediate byte three; three bytes, two cycles.
// - Clear carry when addressed bit is zero, else keep it; two cycles.
// - Complemented-bit form uses inverted bit, bit itself untouched.
// - Carry-AND takes only direct bits and changes no flag but carry.
// - Compare-jump advances past instruction, then adds displacement if unequal.
// - Compare-jump sets carry when first is unsigned-less, else clears it.
// - Indirect RAM versus immediate compare-jump; three bytes, two cycles.
// - Byte AND writes only its destination and leaves status flags alone.
// - Byte AND on the output port reads the latch, not the pins.
// ---------------------------------------------------------------
package lcb_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [4:0] OPC_AND_RN = 5'h0b;
  localparam logic [7:0] OPC_AND_DIR = 8'h55;
  localparam logic [6:0] OPC_AND_IND = 7'h2b;
  localparam logic [7:0] OPC_AND_IMM = 8'h54;
  localparam logic [7:0] OPC_DIR_A = 8'h52;
  localparam logic [7:0] OPC_DIR_IMM = 8'h53;
  localparam logic [7:0] OPC_C_BIT = 8'h82;
  localparam logic [7:0] OPC_C_NBIT = 8'hb0;
  localparam logic [7:0] OPC_CJ_DIR = 8'hb5;
  localparam logic [7:0] OPC_CJ_IMM = 8'hb4;
  localparam logic [4:0] OPC_CJ_RN = 5'h17;
  localparam logic [6:0] OPC_CJ_IND = 7'h5b;
  // ---------------------------------------------------------------
  // Special byte addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PSW = 8'hd0;
  localparam logic [7:0] ADDR_ACC = 8'he0;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;
  localparam int CARRY_POS = 7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] PORT1_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // Clocks that make one machine cycle
  localparam int CLKS_PER_MC = 3;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    K_NOP, K_AND_RN, K_AND_DIR, K_AND_IND, K_AND_IMM, K_DIR_A,
    K_DIR_IMM, K_C_BIT, K_C_NBIT, K_CJ_DIR, K_CJ_IMM, K_CJ_RN, K_CJ_IND
  } lcb_kind_type;
  typedef enum logic [3:0] {
    ST_OPC = 4'b0001,
    ST_B2 = 4'b0010,
    ST_B3 = 4'b0100,
    ST_EXE = 4'b1000
  } lcb_state_type;
endpackage : lcb_pkg

// File: inc/lcb_dec_if.sv
// Decode request and answer between the core and its decoder.
// Assumes purely combinational decode within one clock.
`timescale 1ns/1ps
interface lcb_dec_if;
  import lcb_pkg::*;
  logic [7:0] opcode;
  lcb_kind_type kind;
  logic [1:0] len;
  logic [1:0] cycles;
  logic legal;
  modport dec (input opcode, output kind, len, cycles, legal);
  modport core (output opcode, input kind, len, cycles, legal);
endinterface : lcb_dec_if

// File: design/lcb_decoder.sv
// Opcode decoder: instruction kind, length in bytes, machine cycles.
// Assumes the opcode is stable for the clock in which it is used.
`timescale 1ns/1ps
module lcb_decoder import lcb_pkg::*; (
  // Decode port
  lcb_dec_if.dec dec
);
  wire logic [7:0] op = dec.opcode;
  // ---------------------------------------------------------------
  // Kind
  // ---------------------------------------------------------------
  assign dec.kind =
    (op[7:3] == OPC_AND_RN) ? K_AND_RN :
    (op == OPC_AND_DIR) ? K_AND_DIR :
    (op[7:1] == OPC_AND_IND) ? K_AND_IND :
    (op == OPC_AND_IMM) ? K_AND_IMM :
    (op == OPC_DIR_A) ? K_DIR_A :
    (op == OPC_DIR_IMM) ? K_DIR_IMM :
    (op == OPC_C_BIT) ? K_C_BIT :
    (op == OPC_C_NBIT) ? K_C_NBIT :
    (op == OPC_CJ_DIR) ? K_CJ_DIR :
    (op == OPC_CJ_IMM) ? K_CJ_IMM :
    (op[7:3] == OPC_CJ_RN) ? K_CJ_RN :
    (op[7:1] == OPC_CJ_IND) ? K_CJ_IND : K_NOP;
  assign dec.legal = (dec.kind != K_NOP);
  // ---------------------------------------------------------------
  // Length and cycles
  // ---------------------------------------------------------------
  wire logic one_byte = (dec.kind == K_AND_RN) || (dec.kind == K_AND_IND)
    || (dec.kind == K_NOP);
  wire logic three_byte = (dec.kind == K_DIR_IMM) || (dec.kind >= K_CJ_DIR);
  assign dec.len = one_byte ? 2'd1 : three_byte ? 2'd3 : 2'd2;
  // Unknown opcodes retire as one-byte one-cycle no-ops
  assign dec.cycles = (three_byte || dec.kind == K_C_BIT
    || dec.kind == K_C_NBIT) ? 2'd2 : 2'd1;
endmodule : lcb_decoder

// File: design/lcb_core.sv
// Fetch and execute of the byte AND, carry AND and compare-jump forms.
// Assumes program memory answers prog_addr in the same clock.
`timescale 1ns/1ps
module lcb_core import lcb_pkg::*; #(
  parameter int CLKS_PER_CYCLE = CLKS_PER_MC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Program memory
  output logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  // Port one
  input wire logic [7:0] port_one_pins,
  output logic [7:0] port_one_latch,
  // Status
  output logic [7:0] acc,
  output logic [7:0] psw,
  output logic retire,
  output logic illegal
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lcb_state_type state;
  lcb_state_type next_state;
  logic [15:0] program_counter;
  logic [7:0] opcode;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [7:0] cnt;
  logic [7:0] p1_meta;
  logic [7:0] p1_sync;
  logic [7:0] ram [0:127];
  lcb_dec_if dif();

  lcb_decoder u_dec (
    .dec(dif)
  );

  // Decode the live opcode while it is being fetched
  assign dif.opcode = (state == ST_OPC) ? prog_data : opcode;
  assign prog_addr = program_counter;

  // ---------------------------------------------------------------
  // Operand reads
  // ---------------------------------------------------------------
  // Read-modify-write sees the port latch, plain reads see the pins
  // Sources come in as arguments so the assigns below track them
  function automatic logic [7:0] rd_direct(input logic [7:0] a,
                                           input logic [7:0] ram_v,
                                           input logic [7:0] port_v,
                                           input logic [7:0] acc_v,
                                           input logic [7:0] psw_v);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) begin
      v = ram_v;
    end else begin
      case (a)
        ADDR_ACC: v = acc_v;
        ADDR_PSW: v = psw_v;
        ADDR_PORT1: v = port_v;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : rd_direct

  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'b000} : {BIT_AREA_HI, b[6:3]};
  endfunction : bit_byte

  lcb_kind_type kind;
  assign kind = dif.kind;
  wire logic [6:0] rn_addr = {2'b00, psw[4:3], opcode[2:0]};
  wire logic [6:0] ptr_addr = {2'b00, psw[4:3], 2'b00, opcode[0]};
  wire logic [7:0] rn_val = ram[rn_addr];
  wire logic [7:0] ptr_val = ram[ptr_addr];
  // Upper indirect space is not fitted; it reads as zero
  wire logic [7:0] ind_val = ptr_val[7] ? 8'h00 : ram[ptr_val[6:0]];
  wire logic [7:0] bit_addr = bit_byte(b2);
  wire logic [7:0] dir_plain =
    rd_direct(b2, ram[b2[6:0]], p1_sync, acc, psw);
  wire logic [7:0] dir_rmw =
    rd_direct(b2, ram[b2[6:0]], port_one_latch, acc, psw);
  wire logic [7:0] bit_src =
    rd_direct(bit_addr, ram[bit_addr[6:0]], p1_sync, acc, psw);
  wire logic bit_val = bit_src[b2[2:0]];

  // ---------------------------------------------------------------
  // Byte AND datapath
  // ---------------------------------------------------------------
  wire logic to_acc = (kind == K_AND_RN) || (kind == K_AND_DIR)
    || (kind == K_AND_IND) || (kind == K_AND_IMM);
  wire logic to_dir = (kind == K_DIR_A) || (kind == K_DIR_IMM);
  wire logic [7:0] and_src =
    (kind == K_AND_RN) ? rn_val :
    (kind == K_AND_DIR) ? dir_plain :
    (kind == K_AND_IND) ? ind_val :
    (kind == K_AND_IMM) ? b2 :
    (kind == K_DIR_A) ? acc : b3;
  wire logic [7:0] and_dst = to_dir ? dir_rmw : acc;
  wire logic [7:0] and_res = and_src & and_dst;

  // ---------------------------------------------------------------
  // Compare datapath
  // ---------------------------------------------------------------
  wire logic is_cj = (kind == K_CJ_DIR) || (kind == K_CJ_IMM)
    || (kind == K_CJ_RN) || (kind == K_CJ_IND);
  wire logic [7:0] cmp_a =
    (kind == K_CJ_RN) ? rn_val :
    (kind == K_CJ_IND) ? ind_val : acc;
  wire logic [7:0] cmp_b = (kind == K_CJ_DIR) ? dir_plain : b2;
  wire logic cmp_lt = cmp_a < cmp_b;
  wire logic [15:0] rel = {{8{b3[7]}}, b3};

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  wire logic [7:0] total = 8'(dif.cycles * CLKS_PER_CYCLE);
  wire logic exec = (state == ST_EXE) && (cnt == total - 8'd1);
  wire logic fetch = (state == ST_OPC) || (state == ST_B2)
    || (state == ST_B3);

  always_comb begin
    case (state)
      ST_OPC: next_state = (dif.len == 2'd1) ? ST_EXE : ST_B2;
      ST_B2: next_state = (dif.len == 2'd3) ? ST_B3 : ST_EXE;
      ST_B3: next_state = ST_EXE;
      ST_EXE: next_state = exec ? ST_OPC : ST_EXE;
      default: next_state = ST_OPC;
    endcase
  end

  // ---------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------
  wire logic dir_we = exec && to_dir;
  wire logic carry_we = exec && (is_cj || kind == K_C_BIT
    || kind == K_C_NBIT);
  // Carry only ever clears on the bit forms
  wire logic next_carry = is_cj ? cmp_lt :
    (psw[CARRY_POS] & (bit_val ^ (kind == K_C_NBIT)));
  wire logic [7:0] next_acc =
    (exec && to_acc) ? and_res :
    (dir_we && b2 == ADDR_ACC) ? and_res : acc;
  wire logic [7:0] next_psw =
    (dir_we && b2 == ADDR_PSW) ? and_res :
    carry_we ? {next_carry, psw[6:0]} : psw;
  wire logic [7:0] next_p1 =
    (dir_we && b2 == ADDR_PORT1) ? and_res : port_one_latch;
  wire logic [15:0] next_pc =
    fetch ? program_counter + 16'd1 :
    (exec && is_cj && cmp_a != cmp_b) ? program_counter + rel :
    program_counter;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_OPC;
      program_counter <= PC_RESET;
      acc <= ACC_RESET;
      psw <= PSW_RESET;
      port_one_latch <= PORT1_RESET;
      cnt <= 8'h00;
      retire <= 1'b0;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      program_counter <= next_pc;
      acc <= next_acc;
      psw <= next_psw;
      port_one_latch <= next_p1;
      cnt <= (state == ST_OPC) ? 8'h01 : cnt + 8'h01;
      retire <= exec;
      illegal <= exec && !dif.legal;
    end
  end

  // Instruction bytes; reset not needed as each is fetched before use
  always_ff @(posedge clk) begin
    if (state == ST_OPC) opcode <= prog_data;
    if (state == ST_B2) b2 <= prog_data;
    if (state == ST_B3) b3 <= prog_data;
  end

  // Port pins are asynchronous to the core
  always_ff @(posedge clk) begin
    p1_meta <= port_one_pins;
    p1_sync <= p1_meta;
  end

  // Internal RAM, written only by the direct-destination AND
  always_ff @(posedge clk) begin
    if (dir_we && !b2[7]) ram[b2[6:0]] <= and_res;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] start_pc;
  logic [7:0] gap;
  logic seen;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_pc <= PC_RESET;
      gap <= 8'h00;
      seen <= 1'b0;
    end else begin
      if (exec) start_pc <= next_pc;
      gap <= exec ? 8'h01 : gap + 8'h01;
      if (exec) seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_and_rn;
    exec && kind == K_AND_RN |=> acc == ($past(acc) & $past(rn_val));
  endproperty
  a_and_rn: assert property (p_and_rn)
    else $error("AND with working register gave wrong accumulator");

  property p_and_dir;
    exec && kind == K_AND_DIR |=> acc == ($past(acc) & $past(dir_plain));
  endproperty
  a_and_dir: assert property (p_and_dir)
    else $error("AND with direct byte gave wrong accumulator");

  property p_len;
    exec |-> program_counter == 16'(start_pc + {14'h0, dif.len});
  endproperty
  a_len: assert property (p_len)
    else $error("Counter not advanced by instruction length");

  property p_cycles;
    exec && seen |-> gap == total;
  endproperty
  a_cycles: assert property (p_cycles)
    else $error("Instruction took wrong number of clocks");

  property p_cj_shape;
    exec && is_cj |-> dif.len == 2'd3 && dif.cycles == 2'd2;
  endproperty
  a_cj_shape: assert property (p_cj_shape)
    else $error("Compare-jump not three bytes and two cycles");

  property p_carry_bit;
    exec && kind == K_C_BIT |=>
      psw[CARRY_POS] == ($past(psw[CARRY_POS]) & $past(bit_val));
  endproperty
  a_carry_bit: assert property (p_carry_bit)
    else $error("Carry AND bit result wrong");

  property p_carry_nbit;
    exec && kind == K_C_NBIT |=>
      psw[CARRY_POS] == ($past(psw[CARRY_POS]) & !$past(bit_val));
  endproperty
  a_carry_nbit: assert property (p_carry_nbit)
    else $error("Carry AND complemented bit result wrong");

  property p_carry_only;
    exec && (kind == K_C_BIT || kind == K_C_NBIT) |=>
      psw[6:0] == $past(psw[6:0]) && $stable(acc) && $stable(port_one_latch);
  endproperty
  a_carry_only: assert property (p_carry_only)
    else $error("Carry AND disturbed other state");

  property p_branch;
    exec && is_cj |=> program_counter == 16'($past(program_counter)
      + (($past(cmp_a) != $past(cmp_b)) ? $past(rel) : 16'h0000));
  endproperty
  a_branch: assert property (p_branch)
    else $error("Compare-jump target wrong");

  property p_cj_carry;
    exec && is_cj |=> psw[CARRY_POS] == ($past(cmp_a) < $past(cmp_b))
      ##1 $stable(acc);
  endproperty
  a_cj_carry: assert property (p_cj_carry)
    else $error("Compare-jump carry wrong");

  property p_and_flags;
    exec && to_acc |=> $stable(psw) && $stable(port_one_latch);
  endproperty
  a_and_flags: assert property (p_and_flags)
    else $error("Byte AND touched flags or port");

  property p_port_rmw;
    exec && to_dir && b2 == ADDR_PORT1 |=>
      port_one_latch == ($past(port_one_latch) & $past(and_src));
  endproperty
  a_port_rmw: assert property (p_port_rmw)
    else $error("Port AND did not use latch value");

  property p_and_imm;
    exec && kind == K_AND_IMM |=> acc == ($past(acc) & $past(b2));
  endproperty
  a_and_imm: assert property (p_and_imm)
    else $error("AND with immediate gave wrong accumulator");

  property p_dir_write;
    exec && to_dir && !b2[7] |=>
      ram[$past(b2[6:0])] == ($past(and_src) & $past(dir_rmw));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("AND to direct byte wrote wrong value");

  property p_cj_keep;
    exec && kind == K_CJ_RN |=> $stable(acc) && rn_val == $past(rn_val);
  endproperty
  a_cj_keep: assert property (p_cj_keep)
    else $error("Compare-jump modified a compared operand");

  c_branch: cover property (exec && kind == K_CJ_RN && cmp_a != cmp_b);
  c_dir_imm: cover property (exec && kind == K_DIR_IMM);
  c_nbit: cover property (exec && kind == K_C_NBIT && bit_val);
  c_ind: cover property (exec && kind == K_CJ_IND && cmp_a == cmp_b);
endmodule : lcb_core

// File: testbench/lcb_prog_mem.sv
// Program memory model facing the core's fetch port.
// Assumes the core shows prog_addr and samples the byte in the same clock.
`timescale 1ns/1ps
module lcb_prog_mem (
  // Fetch port
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Unwritten bytes read ff below address 100 and 00 above it, never an unknown that sim might settle
  logic [7:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hff;
    end
  end
  // Always selected, so the byte answers in the same clock
  assign data = (addr[15:8] == 8'h00) ? mem[addr[7:0]] : ~mem[addr[7:0]];
  // ---------------------------------------------------------------
  // Loader
  // ---------------------------------------------------------------
  task automatic load(input logic [7:0] a, input logic [23:0] b,
                      input int n);
    for (int i = 0; i < n; i++) begin
      mem[a + i] = b[23 - 8 * i -: 8];
    end
  endtask : load
endmodule : lcb_prog_mem

// File: testbench/tb.sv
// Self-checking bench: runs a fixed program through the core.
// Assumes acc and psw reset to zero, so results are built from clears.
`timescale 1ns/1ps
module tb;
  import lcb_pkg::*;
  logic clk;
  logic rst_n;
  logic [15:0] prog_addr;
  logic [7:0] prog_data;
  logic [7:0] port_one_pins;
  logic [7:0] port_one_latch;
  logic [7:0] acc;
  logic [7:0] psw;
  logic retire;
  logic illegal;
  int err_total;
  int n_tests;
  lcb_core #(.CLKS_PER_CYCLE(CLKS_PER_MC)) i_lcb_core (
    .clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .port_one_pins(port_one_pins),
    .port_one_latch(port_one_latch), .acc(acc), .psw(psw),
    .retire(retire), .illegal(illegal));
  lcb_prog_mem i_lcb_prog_mem (.addr(prog_addr), .data(prog_data));
  // ---------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Waits for retire, checks its spacing and the visible state
  task automatic step(input logic [15:0] clks, input logic [15:0] addr,
                      input logic [7:0] e_acc, input logic [7:0] e_psw,
                      input logic [7:0] e_latch, input logic e_ill);
    logic [15:0] n;
    n = 16'h0000;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (retire !== 1'b1 && n < 16'h0014);
    check(n, clks);
    check(prog_addr, addr);
    check({8'h00, acc}, {8'h00, e_acc});
    check({8'h00, psw}, {8'h00, e_psw});
    check({8'h00, port_one_latch}, {8'h00, e_latch});
    check({15'h0000, illegal}, {15'h0000, e_ill});
  endtask : step
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check(prog_addr, PC_RESET);
    check({acc, psw}, {ACC_RESET, PSW_RESET});
    check({port_one_latch, 7'h00, retire}, {PORT1_RESET, 8'h00});
    $display("test reset done");
  endtask : t_reset
  task automatic t_port_and();
    step(16'h6, 16'h0003, 8'h00, 8'h00, 8'h73, 1'b0);
    // Pins read ff, so only a latch read gives 70
    step(16'h6, 16'h0006, 8'h00, 8'h00, 8'h70, 1'b0);
    $display("test port_and done");
  endtask : t_port_and
  task automatic t_dir_write();
    step(16'h3, 16'h0008, 8'h00, 8'h00, 8'h70, 1'b0);
    $display("test dir_write done");
  endtask : t_dir_write
  task automatic t_compare_jump_not_equal_reg();
    // Working reg seven cleared, 00 < 60: carry set, 0b + 10
    step(16'h6, 16'h001b, 8'h00, 8'h80, 8'h70, 1'b0);
    $display("test compare_jump_not_equal_reg done");
  endtask : t_compare_jump_not_equal_reg
  task automatic t_compare_jump_not_equal_imm();
    step(16'h6, 16'h001e, 8'h00, 8'h00, 8'h70, 1'b0);
    // Backward displacement f0 from 21
    step(16'h6, 16'h0011, 8'h00, 8'h80, 8'h70, 1'b0);
    $display("test compare_jump_not_equal_imm done");
  endtask : t_compare_jump_not_equal_imm
  task automatic t_carry_and();
    step(16'h6, 16'h0013, 8'h00, 8'h80, 8'h70, 1'b0);
    step(16'h6, 16'h0015, 8'h00, 8'h00, 8'h70, 1'b0);
    $display("test carry_and done");
  endtask : t_carry_and
  task automatic t_compare_jump_not_equal_dir();
    step(16'h6, 16'h0028, 8'h00, 8'h80, 8'h70, 1'b0);
    $display("test compare_jump_not_equal_dir done");
  endtask : t_compare_jump_not_equal_dir
  task automatic t_and_acc();
    step(16'h3, 16'h002a, 8'h00, 8'h80, 8'h70, 1'b0);
    step(16'h3, 16'h002c, 8'h00, 8'h80, 8'h70, 1'b0);
    $display("test and_acc done");
  endtask : t_and_acc
  task automatic t_and_reg_ind();
    step(16'h3, 16'h002e, 8'h00, 8'h80, 8'h70, 1'b0);
    step(16'h3, 16'h002f, 8'h00, 8'h80, 8'h70, 1'b0);
    step(16'h3, 16'h0030, 8'h00, 8'h80, 8'h70, 1'b0);
    $display("test and_reg_ind done");
  endtask : t_and_reg_ind
  task automatic t_compare_jump_not_equal_ind();
    // Equal operands: no branch, carry cleared
    step(16'h6, 16'h0033, 8'h00, 8'h00, 8'h70, 1'b0);
    step(16'h3, 16'h0034, 8'h00, 8'h00, 8'h70, 1'b1);
    $display("test compare_jump_not_equal_ind done");
  endtask : t_compare_jump_not_equal_ind
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    n_tests = 0;
    rst_n = 1'b0;
    port_one_pins = 8'hff;
    // Let the memory fill with ff before the program goes in
    #1;
    i_lcb_prog_mem.load(8'h00, 24'h539073, 3);
    i_lcb_prog_mem.load(8'h03, 24'h5390f0, 3);
    i_lcb_prog_mem.load(8'h06, 24'h5207bf, 3);
    i_lcb_prog_mem.load(8'h09, 24'h601000, 2);
    i_lcb_prog_mem.load(8'h11, 24'h8290b0, 3);
    i_lcb_prog_mem.load(8'h14, 24'h91b590, 3);
    i_lcb_prog_mem.load(8'h17, 24'h100000, 1);
    i_lcb_prog_mem.load(8'h1b, 24'hb40005, 3);
    i_lcb_prog_mem.load(8'h1e, 24'hb405f0, 3);
    i_lcb_prog_mem.load(8'h28, 24'h54ff55, 3);
    i_lcb_prog_mem.load(8'h2b, 24'h905200, 3);
    i_lcb_prog_mem.load(8'h2e, 24'h5856b6, 3);
    i_lcb_prog_mem.load(8'h31, 24'h0005a5, 3);
    repeat (12) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    // Next edge is the first fetch, and step must count it
    rst_n <= 1'b1;
    t_port_and();
    t_dir_write();
    t_compare_jump_not_equal_reg();
    t_compare_jump_not_equal_imm();
    t_carry_and();
    t_compare_jump_not_equal_dir();
    t_and_acc();
    t_and_reg_ind();
    t_compare_jump_not_equal_ind();
    report_and_stop();
  end
endmodule : tb
